// ---- hdl/tbec_top.sv ----
// six-channel event counter timers with an apb register slave
// Functional notes
// - on pin source, count rising, falling or both edges of the event input pin as selected.
// - alternatively count underflow events of a chained neighbouring timer.
// - each counted event decrements the count, and underflow reloads from the reload register.
// - a programmed value n gives one underflow every n+1 counted events.
// - counting starts when software sets the channel run bit.
// - clearing the run bit stops counting and the count holds.
// - each underflow raises the channel interrupt request.
// - reading the count register returns the live count.
// - a count write while stopped loads both reload register and counter.
// - a count write while running loads only the reload register, used at the next reload.
// - writing 1 to the prescaler reset bit restarts the peripheral clock prescaler.
// - the polarity field in bits 3:2 applies only with pin source and is ignored when chained.
// - with bit 7 of the mode register set, each chained timer interrupt request is an event.
// - chained events come from the raw request, free of any interrupt enable or priority.
`timescale 1ns/1ps
module tbec_top
    import tbec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TBEC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [TBEC_NCH-1:0] event_input_pin,
    output logic [TBEC_NCH-1:0] timer_irq,
    output logic presc_tick
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [TBEC_NCH-1:0] run_bit_r;
    tbec_mode_t mode_ctrl_r [TBEC_NCH];
    logic [TBEC_CW-1:0] count_r [TBEC_NCH];
    logic [TBEC_CW-1:0] reload_r [TBEC_NCH];
    logic [TBEC_NCH-1:0] pin_edge;
    logic [TBEC_NCH-1:0] chain_ev;
    logic [TBEC_NCH-1:0] count_ev;
    logic [TBEC_NCH-1:0] underflow;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic setup;
    logic wr_acc;
    logic [2:0] bank;
    logic [2:0] ch;
    logic aligned;
    logic ch_ok;
    logic hit_run;
    logic hit_presc;
    logic hit_mode;
    logic hit_count;
    logic mapped;
    logic [31:0] rd_nxt;
    logic presc_clr;

    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
    assign bank = paddr[7:5];
    assign ch = paddr[4:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign ch_ok = (ch < 3'(TBEC_NCH));
    assign hit_run = (paddr == TBEC_OFS_RUN);
    assign hit_presc = (paddr == TBEC_OFS_PRESC_RST);
    assign hit_mode = aligned && ch_ok && (bank == TBEC_BANK_MODE);
    assign hit_count = aligned && ch_ok && (bank == TBEC_BANK_COUNT);
    assign mapped = hit_run | hit_presc | hit_mode | hit_count;

    // read mux; the prescaler reset bit is write-only and reads zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_run) begin
            rd_nxt[TBEC_NCH-1:0] = run_bit_r;
        end else if (hit_mode) begin
            rd_nxt[7:0] = mode_ctrl_r[ch];
        end else if (hit_count) begin
            rd_nxt[TBEC_CW-1:0] = count_r[ch];
        end
    end

    // answer is prepared in the setup cycle: zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    // ----------------------------------------------------------------
    // run bits and prescaler reset request
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_bit_r <= TBEC_RUN_RST;
        end else if (wr_acc && hit_run) begin
            run_bit_r <= pwdata[TBEC_NCH-1:0];
        end
    end

    assign presc_clr = wr_acc & hit_presc & pwdata[TBEC_PRESC_RST_BIT];

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // event counting does not use the tick; it only drives the presc_tick output
    tbec_prescaler u_tbec_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clr(presc_clr),
        .tick_o(presc_tick)
    );

    // ----------------------------------------------------------------
    // per-channel counters
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < TBEC_NCH; gi++) begin : g_ch
            localparam int SRC = (gi == 0) ? 2 : (gi == 3) ? 5 : gi - 1;
            logic wr_cnt;
            logic [TBEC_CW-1:0] gap_r;
            logic gap_ok_r;

            assign wr_cnt = wr_acc && hit_count && (ch == 3'(gi));

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mode_ctrl_r[gi] <= TBEC_MODE_RST;
                end else if (wr_acc && hit_mode && (ch == 3'(gi))) begin
                    mode_ctrl_r[gi] <= pwdata[7:0];
                end
            end

            tbec_edge u_tbec_edge (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(event_input_pin[gi]),
                .pol(mode_ctrl_r[gi].polarity_sel),
                .edge_o(pin_edge[gi])
            );

            // raw underflow of the neighbour, no enable or priority gating
            assign chain_ev[gi] = timer_irq[SRC];
            // polarity only steers the pin path, so it drops out when chained
            assign count_ev[gi] = run_bit_r[gi] &
                (mode_ctrl_r[gi].event_source_sel ? chain_ev[gi] : pin_edge[gi]);
            assign underflow[gi] = count_ev[gi] && (count_r[gi] == '0);

            // reload register: any count write lands here
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    reload_r[gi] <= TBEC_COUNT_RST;
                end else if (wr_cnt) begin
                    reload_r[gi] <= pwdata[TBEC_CW-1:0];
                end
            end

            // counter: n+1 events between underflows
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    count_r[gi] <= TBEC_COUNT_RST;
                end else if (wr_cnt && !run_bit_r[gi]) begin
                    count_r[gi] <= pwdata[TBEC_CW-1:0];
                end else if (underflow[gi]) begin
                    count_r[gi] <= reload_r[gi];
                end else if (count_ev[gi]) begin
                    count_r[gi] <= count_r[gi] - 1'b1;
                end
            end

            // one-cycle request per underflow
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    timer_irq[gi] <= 1'b0;
                end else begin
                    timer_irq[gi] <= underflow[gi];
                end
            end

            // --------------------------------------------------------
            // period helper
            // --------------------------------------------------------
            // a running write leaves the current period unknown, so skip it
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gap_r <= '0;
                    gap_ok_r <= 1'b0;
                end else if (wr_cnt) begin
                    gap_r <= '0;
                    gap_ok_r <= !run_bit_r[gi];
                end else if (underflow[gi]) begin
                    gap_r <= '0;
                    gap_ok_r <= 1'b1;
                end else if (count_ev[gi]) begin
                    gap_r <= gap_r + 1'b1;
                end
            end

            // --------------------------------------------------------
            // checks
            // --------------------------------------------------------
            a_cnt_decrement: assert property (@(posedge pclk) disable iff (!presetn)
                count_ev[gi] && count_r[gi] != '0 && !wr_cnt
                |=> count_r[gi] == $past(count_r[gi]) - 16'h0001)
                else $error("counter did not decrement on event");
            a_underflow_reload: assert property (@(posedge pclk) disable iff (!presetn)
                count_ev[gi] && count_r[gi] == '0 && !wr_cnt
                |=> count_r[gi] == $past(reload_r[gi]) && timer_irq[gi])
                else $error("underflow did not reload and request");
            a_irq_cause: assert property (@(posedge pclk) disable iff (!presetn)
                timer_irq[gi] |-> $past(run_bit_r[gi]) && $past(count_r[gi]) == '0)
                else $error("request raised without underflow");
            a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
                !run_bit_r[gi] && !wr_cnt |=> count_r[gi] == $past(count_r[gi]))
                else $error("stopped counter changed");
            a_stopped_write: assert property (@(posedge pclk) disable iff (!presetn)
                wr_cnt && !run_bit_r[gi]
                |=> count_r[gi] == $past(pwdata[15:0]) && reload_r[gi] == count_r[gi])
                else $error("stopped write did not load both");
            a_running_write: assert property (@(posedge pclk) disable iff (!presetn)
                wr_cnt && run_bit_r[gi] && !count_ev[gi]
                |=> reload_r[gi] == $past(pwdata[15:0]) && $stable(count_r[gi]))
                else $error("running write touched the counter");
            a_chain_event: assert property (@(posedge pclk) disable iff (!presetn)
                run_bit_r[gi] && mode_ctrl_r[gi].event_source_sel && timer_irq[SRC]
                && count_r[gi] != '0 && !wr_cnt
                |=> count_r[gi] == $past(count_r[gi]) - 16'h0001)
                else $error("chained request not counted");
            a_pin_ignored: assert property (@(posedge pclk) disable iff (!presetn)
                mode_ctrl_r[gi].event_source_sel && !timer_irq[SRC] && !wr_cnt
                |=> $stable(count_r[gi]))
                else $error("pin edge counted while chained");
            a_period_len: assert property (@(posedge pclk) disable iff (!presetn)
                underflow[gi] && gap_ok_r |-> gap_r == reload_r[gi])
                else $error("underflow period is not reload plus one");
            a_pin_event: assert property (@(posedge pclk) disable iff (!presetn)
                run_bit_r[gi] && !mode_ctrl_r[gi].event_source_sel && pin_edge[gi]
                && count_r[gi] != '0 && !wr_cnt
                |=> count_r[gi] == $past(count_r[gi]) - 16'h0001)
                else $error("pin edge not counted");
            a_stop_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
                !run_bit_r[gi] |=> !timer_irq[gi])
                else $error("stopped timer raised a request");
            a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
                wr_acc && hit_mode && ch == 3'(gi) |=> mode_ctrl_r[gi] == $past(pwdata[7:0]))
                else $error("mode write not stored");
            a_read_mode: assert property (@(posedge pclk) disable iff (!presetn)
                setup && !pwrite && hit_mode && ch == 3'(gi)
                |=> prdata[7:0] == $past(mode_ctrl_r[gi]))
                else $error("mode read back wrong");
            a_refused_reload: assert property (@(posedge pclk) disable iff (!presetn)
                psel && penable && pready && pslverr |=> $stable(reload_r[gi]))
                else $error("refused write changed a reload value");
            c_underflow: cover property (@(posedge pclk) disable iff (!presetn)
                underflow[gi] && reload_r[gi] != '0);
            c_chain: cover property (@(posedge pclk) disable iff (!presetn)
                mode_ctrl_r[gi].event_source_sel && count_ev[gi]);
            c_run_write: cover property (@(posedge pclk) disable iff (!presetn)
                wr_cnt && run_bit_r[gi]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // bus checks
    // ----------------------------------------------------------------
    a_run_start: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit_run |=> run_bit_r == $past(pwdata[5:0]))
        else $error("run bits not taken from write");
    a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_count |=> pready && prdata[15:0] == $past(count_r[ch]))
        else $error("count read returned wrong value");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped |=> pready && pslverr)
        else $error("unmapped access not flagged");
    a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> $past(setup))
        else $error("ready without a setup cycle");
    a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag outside an access");
    a_err_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pslverr |=> $stable(run_bit_r))
        else $error("refused write changed the run bits");

    a_read_run: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_run |=> prdata == {26'h0, $past(run_bit_r)})
        else $error("run bits read back wrong");
    a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite |=> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_presc_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_presc |=> prdata == 32'h0000_0000)
        else $error("write-only prescaler bit read nonzero");
    a_tick_restart: assert property (@(posedge pclk) disable iff (!presetn)
        presc_clr |=> !presc_tick)
        else $error("tick survived a prescaler reset");

    // ----------------------------------------------------------------
    // chain map, spelled out so a wrong index in the loop shows up
    // ----------------------------------------------------------------
    a_chain_ring: assert property (@(posedge pclk) disable iff (!presetn)
        chain_ev == {timer_irq[4], timer_irq[3], timer_irq[5], timer_irq[1], timer_irq[0],
            timer_irq[2]})
        else $error("chained source mapping wrong");

    c_presc_reset: cover property (@(posedge pclk) disable iff (!presetn) presc_clr);

endmodule

// ---- hdl/tbec_pkg.sv ----
// shared constants and types for the six-channel event counter block
package tbec_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int TBEC_NCH = 6;
    localparam int TBEC_CW = 16;
    localparam int TBEC_AW = 8;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] TBEC_OFS_RUN = 8'h00;
    localparam logic [7:0] TBEC_OFS_PRESC_RST = 8'h04;
    localparam logic [7:0] TBEC_OFS_MODE_BASE = 8'h20;
    localparam logic [7:0] TBEC_OFS_COUNT_BASE = 8'h40;
    // address bits 7:5 select a bank, bits 4:2 the channel
    localparam logic [2:0] TBEC_BANK_MODE = 3'h1;
    localparam logic [2:0] TBEC_BANK_COUNT = 3'h2;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int TBEC_MODE_SRC_BIT = 7;
    localparam int TBEC_MODE_POL_LSB = 2;
    localparam int TBEC_PRESC_RST_BIT = 0;
    localparam logic [7:0] TBEC_MODE_RST = 8'h00;
    localparam logic [15:0] TBEC_COUNT_RST = 16'h0000;
    localparam logic [5:0] TBEC_RUN_RST = 6'h00;

    // ----------------------------------------------------------------
    // peripheral clock prescaler: one tick each time the count wraps
    // ----------------------------------------------------------------
    localparam int TBEC_PRESC_W = 6;
    localparam logic [5:0] TBEC_PRESC_LAST = 6'h3F;

    // active edge select for the pin source
    typedef enum logic [1:0] {
        TBEC_POL_FALL = 2'h0,
        TBEC_POL_RISE = 2'h1,
        TBEC_POL_BOTH = 2'h2,
        TBEC_POL_RSVD = 2'h3
    } tbec_pol_t;

    // mode control register layout
    typedef struct packed {
        logic event_source_sel;
        logic source_sel_lo;
        logic [1:0] rsvd_hi;
        tbec_pol_t polarity_sel;
        logic [1:0] rsvd_lo;
    } tbec_mode_t;

endpackage

// ---- hdl/tbec_edge.sv ----
// pin synchroniser and selectable active-edge detector for one channel
`timescale 1ns/1ps
module tbec_edge
    import tbec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    input wire tbec_pol_t pol,
    output logic edge_o
);

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic rise;
    logic fall;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;

    // one pulse per qualifying edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_o <= 1'b0;
        end else begin
            case (pol)
                TBEC_POL_FALL: edge_o <= fall;
                TBEC_POL_RISE: edge_o <= rise;
                default: edge_o <= rise | fall;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_edge_single: assert property (edge_o |-> $past(sync2_r != prev_r))
        else $error("edge pulse without a synchronised transition");
    a_edge_rise: assert property ((pol == TBEC_POL_RISE) && fall |=> !edge_o)
        else $error("falling edge counted in rising-only mode");

endmodule

// ---- hdl/tbec_prescaler.sv ----
// peripheral clock prescaler with software reset
`timescale 1ns/1ps
module tbec_prescaler
    import tbec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    output logic tick_o
);

    logic [TBEC_PRESC_W-1:0] cnt_r;

    // a reset restarts the divide chain so the next tick is a full period away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else if (clr) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick_o <= (cnt_r == TBEC_PRESC_LAST);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_presc_clear: assert property (clr |=> (cnt_r == '0) && !tick_o)
        else $error("prescaler not restarted by reset request");
    c_presc_clear: cover property (clr);

endmodule

// ---- verification/tbec_pulse_src.sv ----
// external pulse source that toggles selected event input pins
`timescale 1ns/1ps
module tbec_pulse_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [5:0] mask,
    input wire logic [7:0] npulse,
    output logic busy,
    output logic [5:0] pin
);
    int left;
    int hold;
    // random hold of 3 to 10 cycles per level, never below the 2 stable cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= 6'h00;
            busy <= 1'b0;
            left <= 0;
            hold <= 0;
        end else if (!busy) begin
            if (go) begin
                busy <= 1'b1;
                left <= 2 * int'(npulse);
                hold <= 0;
            end
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else if (left == 0) begin
            busy <= 1'b0;
        end else begin
            pin <= pin ^ mask;
            left <= left - 1;
            hold <= 2 + int'($urandom_range(7));
        end
    end
endmodule

// ---- verification/tb_tbec_top.sv ----
// self-checking bench for the event counter block
`timescale 1ns/1ps
module tb_tbec_top;
    import tbec_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] pin;
    logic [5:0] timer_irq;
    logic presc_tick;
    logic go = 1'b0;
    logic [5:0] mask = 6'h00;
    logic [7:0] npulse = 8'h00;
    logic busy;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int tests_run = 0;
    int irq_cnt[6] = '{default: 0};
    int cnt_m[6];
    int rel_m[6];
    int und_m[6];

    tbec_top u_tbec_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_input_pin(pin), .timer_irq(timer_irq),
        .presc_tick(presc_tick));
    tbec_pulse_src u_tbec_pulse_src (.pclk(pclk), .presetn(presetn), .go(go), .mask(mask),
        .npulse(npulse), .busy(busy), .pin(pin));

    initial begin
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        for (int i = 0; i < 6; i++) begin
            if (timer_irq[i] === 1'b1) irq_cnt[i] = irq_cnt[i] + 1;
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic int src_of(int i);
        return (i == 0) ? 2 : (i == 3) ? 5 : i - 1;
    endfunction

    task automatic test_done();
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask

    // one apb transfer; starts and ends just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("wait states", 1, n);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // behavioural counter: n+1 events per underflow
    task automatic model(int c, int ev);
        repeat (ev) begin
            if (cnt_m[c] == 0) begin
                cnt_m[c] = rel_m[c];
                und_m[c]++;
            end else begin
                cnt_m[c]--;
            end
        end
    endtask

    task automatic pulses(logic [5:0] m, int n);
        int k;
        k = 0;
        @(posedge pclk);
        mask <= m;
        npulse <= 8'(n);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        do begin
            @(posedge pclk);
            k++;
        end while (busy !== 1'b0 && k < 5000);
        chk("pulse source idle", 0, busy);
        repeat (8) @(posedge pclk);
    endtask

    function automatic logic [7:0] cnt_a(int c);
        return TBEC_OFS_COUNT_BASE + 8'(4 * c);
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int pol;
        int e;
        int base[6];
        logic [7:0] md;
        void'($urandom(92));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, TBEC_OFS_RUN, 0);
        chk("run rst", TBEC_RUN_RST, rd);
        apb(0, TBEC_OFS_MODE_BASE, 0);
        chk("mode rst", TBEC_MODE_RST, rd);
        apb(0, cnt_a(5), 0);
        chk("count rst", TBEC_COUNT_RST, rd);
        apb(0, 8'hFC, 0);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        apb(0, TBEC_OFS_PRESC_RST, 0);
        chk("presc read", 0, rd);
        apb(1, TBEC_OFS_PRESC_RST, 1);
        e = 0;
        while (presc_tick !== 1'b1 && e < 100) begin
            @(posedge pclk);
            e++;
        end
        chk("presc restart", 32'(TBEC_PRESC_LAST) + 32'h2, e);
        // every polarity code on channel 0, zero reload first
        for (pol = 0; pol < 4; pol++) begin
            apb(1, TBEC_OFS_RUN, 0);
            rel_m[0] = (pol == 0) ? 0 : $urandom_range(4);
            cnt_m[0] = rel_m[0];
            und_m[0] = irq_cnt[0];
            apb(1, TBEC_OFS_MODE_BASE, 32'(pol << 2));
            apb(1, cnt_a(0), rel_m[0]);
            apb(0, cnt_a(0), 0);
            chk("stopped write", rel_m[0], rd);
            apb(1, TBEC_OFS_RUN, 1);
            e = 1 + $urandom_range(6);
            pulses(6'h01, e);
            model(0, (pol >= 2) ? 2 * e : e);
            apb(0, cnt_a(0), 0);
            chk("pin count", cnt_m[0], rd);
            chk("pin irqs", und_m[0], irq_cnt[0]);
        end
        // write while running goes to reload only
        apb(1, TBEC_OFS_MODE_BASE, 32'h04);
        apb(1, TBEC_OFS_RUN, 0);
        apb(1, cnt_a(0), 2);
        apb(1, TBEC_OFS_RUN, 1);
        cnt_m[0] = 2;
        rel_m[0] = 5;
        apb(1, cnt_a(0), 5);
        apb(0, cnt_a(0), 0);
        chk("running write", 2, rd);
        pulses(6'h01, 4);
        model(0, 4);
        apb(0, cnt_a(0), 0);
        chk("new reload", cnt_m[0], rd);
        apb(1, TBEC_OFS_RUN, 0);
        pulses(6'h01, 3);
        apb(0, cnt_a(0), 0);
        chk("stopped hold", cnt_m[0], rd);
        // chained channels see toggling pins that must be ignored
        for (int c = 0; c < 6; c++) begin
            rel_m[c] = (c == 2) ? $urandom_range(3) : int'(c == 1 || c == 3);
            cnt_m[c] = rel_m[c];
            base[c] = irq_cnt[c];
            und_m[c] = base[c];
            md = (c == 0) ? 8'h04 : (c == 3) ? 8'h08 : {4'h8, 2'($urandom_range(3)), 2'h0};
            apb(1, TBEC_OFS_MODE_BASE + 8'(4 * c), md);
            apb(0, TBEC_OFS_MODE_BASE + 8'(4 * c), 0);
            chk("mode readback", md, rd);
            apb(1, cnt_a(c), rel_m[c]);
        end
        apb(1, TBEC_OFS_RUN, 32'h3F);
        apb(0, TBEC_OFS_RUN, 0);
        chk("run readback", 32'h3F, rd);
        e = 2 + $urandom_range(4);
        pulses(6'h3F, e);
        for (int c = 0; c < 6; c++) begin
            model(c, (c == 0) ? e : (c == 3) ? 2 * e : und_m[src_of(c)] - base[src_of(c)]);
            apb(0, cnt_a(c), 0);
            chk("chain count", cnt_m[c], rd);
            chk("chain irqs", und_m[c], irq_cnt[c]);
        end
        test_done();
    end

    initial begin
        #400us;
        err_total++;
        test_done();
    end
endmodule
